/* bench/mci_front_model.sv */
`timescale 1ns/1ps
module mci_front_model (
   // Clock
   input wire mclk_i,
   // Decode handshake
   input wire dec_stall_i,
   output reg dec_valid_o,
   output reg [3:0] dec_op_o,
   // Fetch requester
   input wire fetch_en_i,
   output reg if_req_o
);
   initial begin
      dec_valid_o = 1'b0;
      dec_op_o = 4'h0;
      if_req_o = 1'b0;
   end
   // Fetch wants the bus every cycle while enabled
   always @(posedge mclk_i) if_req_o <= fetch_en_i;
   // Present one class for one edge, retry while refused
   task automatic issue(input logic [3:0] op);
      logic again;
      again = 1'b1;
      while (again) begin
         @(posedge mclk_i);
         dec_valid_o <= 1'b1;
         dec_op_o <= op;
         @(posedge mclk_i);
         dec_valid_o <= 1'b0;
         dec_op_o <= ~op;
         @(negedge mclk_i);
         again = dec_stall_i;
      end
   endtask
endmodule

/* bench/mci_interlock_properties.sv */
`timescale 1ns/1ps
`include "mci_map.vh"
module mci_interlock_properties #(
   parameter [2:0] BUSY_MAC_LONG = 3'h4,
   parameter [2:0] BUSY_MAC_WORD = 3'h2,
   parameter [2:0] BUSY_DMUL_LONG = 3'h4,
   parameter [2:0] BUSY_MUL_WORD = 3'h2
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire dec_valid_i,
   input wire if_req_i,
   input wire dec_stall_o,
   input wire if_grant_o,
   input wire [2:0] ma_phase_o,
   input wire [3:0] ma_op_o,
   input wire ma_stretch_o,
   input wire ma_bus_o,
   input wire ma_mul_o,
   input wire mul_busy_o,
   input wire [2:0] busy_cnt_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // =========================================
   // Multiplier busy counter
   sequence s_done(op);
      ma_mul_o && ma_op_o == op;
   endsequence
   property p_load(op, n);
      s_done(op) |=> busy_cnt_o == n;
   endproperty
   a_load_mac_long: assert property (p_load(4'h1, BUSY_MAC_LONG))
      else $error("long mac busy load wrong");
   a_load_mac_word: assert property (p_load(4'h2, BUSY_MAC_WORD))
      else $error("word mac busy load wrong");
   a_load_dbl_mul: assert property (p_load(4'h3, BUSY_DMUL_LONG))
      else $error("double mul busy load wrong");
   a_load_word_mul: assert property (p_load(4'h4, BUSY_MUL_WORD))
      else $error("word mul busy load wrong");
   a_busy_count_down: assert property (busy_cnt_o > 3'h1 |=>
      busy_cnt_o == $past(busy_cnt_o) - 3'h1) else $error("busy step wrong");
   a_busy_flag_match: assert property (
      mul_busy_o == (busy_cnt_o != 3'h0)) else $error("busy flag wrong");
   a_stretch_needs_busy: assert property (ma_stretch_o |-> mul_busy_o)
      else $error("stretch without busy");
   a_stretch_ends_soon: assert property ($rose(ma_stretch_o) |->
      ##[1:5] !ma_stretch_o) else $error("stretch too long");
   // =========================================
   // Fetch arbitration and decode hold
   a_grant_bus_free: assert property (if_grant_o |-> !ma_bus_o)
      else $error("grant while bus used");
   a_grant_when_free: assert property ($past(if_req_i) && !ma_bus_o
      |-> if_grant_o) else $error("free fetch not granted");
   a_split_next: assert property (
      $past(if_req_i) && if_req_i && ma_bus_o |=> if_grant_o)
      else $error("split fetch lost");
   a_first_holds_dec: assert property (ma_phase_o == 3'h2 &&
      $past(dec_valid_i) |-> dec_stall_o) else $error("decode not held");
endmodule
bind mci_interlock mci_interlock_properties #(
   .BUSY_MAC_LONG(BUSY_MAC_LONG), .BUSY_MAC_WORD(BUSY_MAC_WORD),
   .BUSY_DMUL_LONG(BUSY_DMUL_LONG), .BUSY_MUL_WORD(BUSY_MUL_WORD)
) u_props (.*);

/* bench/tb_top.sv */
`timescale 1ns/1ps
`include "mci_map.vh"
module tb_top;
   reg mclk_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg fetch_en = 1'b0;
   wire dec_valid, dec_stall, if_req, if_grant, stretch, ma_bus, ma_mul;
   wire [3:0] dec_op, ma_op;
   wire [2:0] busy_cnt;
   reg saw_str, saw_stl, saw_split, mul_seen;
   reg clr_q = 1'b0;
   reg [3:0] mul_op;
   reg [2:0] load_cnt;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   reg [2:0] exp_busy [1:4] = '{`MCI_BUSY_MAC_LONG, `MCI_BUSY_MAC_WORD,
      `MCI_BUSY_DMUL_LONG, `MCI_BUSY_MUL_WORD};
   mci_interlock DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .dec_valid_i(dec_valid), .dec_op_i(dec_op), .dec_stall_o(dec_stall),
      .if_req_i(if_req), .if_grant_o(if_grant), .ma_phase_o(),
      .ma_op_o(ma_op), .ma_stretch_o(stretch), .ma_bus_o(ma_bus),
      .ma_mul_o(ma_mul), .mul_busy_o(), .busy_cnt_o(busy_cnt));
   mci_front_model u_fe (.mclk_i(mclk_i), .dec_stall_i(dec_stall),
      .dec_valid_o(dec_valid), .dec_op_o(dec_op), .fetch_en_i(fetch_en),
      .if_req_o(if_req));
   initial forever #20 mclk_i = ~mclk_i;
   // =========================================
   // Observation and timeout
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      mul_seen <= ma_mul;
      if (ma_mul) mul_op <= ma_op;
      if (mul_seen) load_cnt <= busy_cnt;
      if (clr_q) begin
         saw_str <= 1'b0;
         saw_stl <= 1'b0;
         saw_split <= 1'b0;
      end else begin
         if (stretch) saw_str <= 1'b1;
         if (dec_stall) saw_stl <= 1'b1;
         if (if_req && ma_bus && !if_grant) saw_split <= 1'b1;
      end
      if (cyc == 3000) begin
         err_total++;
         print_verdict;
      end
   end
   task chk(input [3:0] got, input [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task clr;
      @(posedge mclk_i);
      clr_q <= 1'b1;
      @(posedge mclk_i);
      clr_q <= 1'b0;
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // =========================================
   // Scenarios
   task t_classes;
      for (int i = 1; i <= 4; i++) begin
         u_fe.issue(i[3:0]);
         repeat (12) @(posedge mclk_i);
         chk(mul_op, i[3:0]);
         chk({1'b0, load_cnt}, {1'b0, exp_busy[i]});
      end
   endtask
   task t_pair(input [3:0] op2, input int gap, input bit exp);
      clr;
      u_fe.issue(`MCI_OP_MAC_LONG);
      repeat (gap) u_fe.issue(`MCI_OP_NONE);
      u_fe.issue(op2);
      repeat (12) @(posedge mclk_i);
      chk({3'h0, saw_str}, {3'h0, exp});
      chk({3'h0, saw_stl}, 4'h1);
   endtask
   task t_fetch;
      clr;
      fetch_en <= 1'b1;
      u_fe.issue(`MCI_OP_MAC_LONG);
      u_fe.issue(`MCI_OP_MAC_LONG);
      repeat (14) @(posedge mclk_i);
      chk({3'h0, saw_split}, 4'h1);
      chk({3'h0, if_grant}, 4'h1);
      fetch_en <= 1'b0;
   endtask
   initial begin
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      t_classes;
      t_pair(`MCI_OP_MAC_LONG, 0, 1'b1);
      t_pair(`MCI_OP_MAC_LONG, 2, 1'b0);
      t_pair(`MCI_OP_MUL_WORD, 3, 1'b0);
      for (int k = 2; k <= 8; k++) t_pair(k[3:0], 0, 1'b1);
      t_fetch;
      print_verdict;
   end
endmodule

/* design/mci_interlock.v */
`timescale 1ns/1ps
`include "mci_map.vh"

module mci_interlock #(
   parameter [`MCI_BUSY_W-1:0] BUSY_MAC_LONG = `MCI_BUSY_MAC_LONG,
   parameter [`MCI_BUSY_W-1:0] BUSY_MAC_WORD = `MCI_BUSY_MAC_WORD,
   parameter [`MCI_BUSY_W-1:0] BUSY_DMUL_LONG = `MCI_BUSY_DMUL_LONG,
   parameter [`MCI_BUSY_W-1:0] BUSY_MUL_WORD = `MCI_BUSY_MUL_WORD
) (
   // Clock and reset
   input wire mclk_i,
   input wire rst_n_i,
   // Decode side
   input wire dec_valid_i,
   input wire [`MCI_OP_W-1:0] dec_op_i,
   output reg dec_stall_o,
   // Instruction fetch side
   input wire if_req_i,
   output reg if_grant_o,
   // Memory access stage and multiplier
   output reg [`MCI_PH_W-1:0] ma_phase_o,
   output reg [`MCI_OP_W-1:0] ma_op_o,
   output reg ma_stretch_o,
   output reg ma_bus_o,
   output reg ma_mul_o,
   output reg mul_busy_o,
   output reg [`MCI_BUSY_W-1:0] busy_cnt_o
);

   // ==========================================================
   // Reset release
   // ==========================================================
   reg rst_s1_q;
   reg rst_s2_q;

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   wire rst_n = rst_s2_q;

   // ==========================================================
   // Instruction class properties
   // ==========================================================
   function two_access;
      input [`MCI_OP_W-1:0] op;
      begin
         two_access = (op == `MCI_OP_MAC_LONG) ||
            (op == `MCI_OP_MAC_WORD) || (op == `MCI_OP_DMUL_LONG);
      end
   endfunction

   function has_access;
      input [`MCI_OP_W-1:0] op;
      begin
         has_access = (op != `MCI_OP_NONE);
      end
   endfunction

   // Whether the last access touches the bus
   function last_uses_bus;
      input [`MCI_OP_W-1:0] op;
      begin
         case (op)
            `MCI_OP_MAC_LONG,
            `MCI_OP_MAC_WORD,
            `MCI_OP_DMUL_LONG,
            `MCI_OP_MUL_WORD,
            `MCI_OP_ST_GPR,
            `MCI_OP_ST_MEM,
            `MCI_OP_LD_GPR,
            `MCI_OP_LD_MEM: last_uses_bus = 1'b1;
            default: last_uses_bus = 1'b0;
         endcase
      end
   endfunction

   function [`MCI_BUSY_W-1:0] busy_len;
      input [`MCI_OP_W-1:0] op;
      begin
         case (op)
            `MCI_OP_MAC_LONG: busy_len = BUSY_MAC_LONG;
            `MCI_OP_MAC_WORD: busy_len = BUSY_MAC_WORD;
            `MCI_OP_DMUL_LONG: busy_len = BUSY_DMUL_LONG;
            `MCI_OP_MUL_WORD: busy_len = BUSY_MUL_WORD;
            default: busy_len = {`MCI_BUSY_W{1'b0}};
         endcase
      end
   endfunction

   // ==========================================================
   // State
   // ==========================================================
   reg ex_vld_q;
   reg [`MCI_OP_W-1:0] ex_op_q;
   reg [`MCI_PH_W-1:0] ph_q;
   reg [`MCI_PH_W-1:0] ph_d;
   reg [`MCI_OP_W-1:0] ma_op_q;
   reg [`MCI_OP_W-1:0] ma_op_d;
   reg [`MCI_BUSY_W-1:0] busy_q;
   reg [`MCI_BUSY_W-1:0] busy_d;
   reg split_q;

   wire in_first = ph_q[1];
   wire in_last = ph_q[2];
   wire busy = (busy_q != {`MCI_BUSY_W{1'b0}});

   // Every last access waits while the multiplier is busy
   wire ma_wait = in_last && busy && !split_q;

   wire bus_now = !split_q && !ma_wait &&
      (in_first || (in_last && last_uses_bus(ma_op_q)));

   // Fetch refused by a memory access takes the next cycle
   wire split_d = bus_now && if_req_i;

   wire last_done = in_last && !ma_wait && !split_q;
   wire first_done = in_first && !split_q;

   // Any two-access class keeps the follower's decode held
   wire go = !split_q && (ph_q[0] || last_done);

   wire issue = go && dec_valid_i;

   // ==========================================================
   // Memory access sequencing
   // ==========================================================
   always @* begin
      ph_d = ph_q;
      ma_op_d = ma_op_q;
      if (first_done) begin
         ph_d = `MCI_PH_LAST;
      end else if (go) begin
         if (ex_vld_q && has_access(ex_op_q)) begin
            ma_op_d = ex_op_q;
            if (two_access(ex_op_q)) begin
               ph_d = `MCI_PH_FIRST;
            end else begin
               ph_d = `MCI_PH_LAST;
            end
         end else begin
            ph_d = `MCI_PH_IDLE;
            ma_op_d = `MCI_OP_NONE;
         end
      end
   end

   // ==========================================================
   // Multiplier busy counter
   // ==========================================================
   always @* begin
      busy_d = busy_q;
      if (last_done && (busy_len(ma_op_q) != {`MCI_BUSY_W{1'b0}})) begin
         busy_d = busy_len(ma_op_q);
      end else if (busy) begin
         busy_d = busy_q - {{(`MCI_BUSY_W-1){1'b0}}, 1'b1};
      end
   end

   // ==========================================================
   // Compute stage next state
   // ==========================================================
   reg ex_vld_d;
   reg [`MCI_OP_W-1:0] ex_op_d;

   // Compute stage advances only when the access stage frees
   always @* begin
      ex_vld_d = ex_vld_q;
      ex_op_d = ex_op_q;
      if (go) begin
         ex_vld_d = issue;
         if (issue) begin
            ex_op_d = dec_op_i;
         end else begin
            ex_op_d = `MCI_OP_NONE;
         end
      end
   end

   // ==========================================================
   // State registers
   // ==========================================================
   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ex_vld_q <= 1'b0;
         ex_op_q <= `MCI_OP_NONE;
      end else begin
         ex_vld_q <= ex_vld_d;
         ex_op_q <= ex_op_d;
      end
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ph_q <= `MCI_PH_IDLE;
         ma_op_q <= `MCI_OP_NONE;
      end else begin
         ph_q <= ph_d;
         ma_op_q <= ma_op_d;
      end
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= {`MCI_BUSY_W{1'b0}};
      end else begin
         busy_q <= busy_d;
      end
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         split_q <= 1'b0;
      end else begin
         split_q <= split_d;
      end
   end

   // ==========================================================
   // Output next values
   // ==========================================================
   wire dec_stall_d = dec_valid_i && !go;
   wire if_grant_d = if_req_i && !bus_now;
   // Access held by a busy multiplier
   wire ma_stretch_d = ma_wait;
   wire ma_bus_d = bus_now;
   wire ma_mul_d = last_done;
   wire mul_busy_d = busy;

   // ==========================================================
   // Registered outputs
   // ==========================================================
   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         dec_stall_o <= 1'b0;
      end else begin
         dec_stall_o <= dec_stall_d;
      end
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         if_grant_o <= 1'b0;
      end else begin
         if_grant_o <= if_grant_d;
      end
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ma_phase_o <= `MCI_PH_IDLE;
      end else begin
         ma_phase_o <= ph_q;
      end
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ma_op_o <= `MCI_OP_NONE;
      end else begin
         ma_op_o <= ma_op_q;
      end
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ma_stretch_o <= 1'b0;
      end else begin
         ma_stretch_o <= ma_stretch_d;
      end
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ma_bus_o <= 1'b0;
      end else begin
         ma_bus_o <= ma_bus_d;
      end
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ma_mul_o <= 1'b0;
      end else begin
         ma_mul_o <= ma_mul_d;
      end
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         mul_busy_o <= 1'b0;
      end else begin
         mul_busy_o <= mul_busy_d;
      end
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt_o <= {`MCI_BUSY_W{1'b0}};
      end else begin
         busy_cnt_o <= busy_q;
      end
   end

endmodule

/* design/mci_map.vh */
`ifndef MCI_MAP_VH
`define MCI_MAP_VH

// Instruction classes presented at decode
`define MCI_OP_W 4
`define MCI_OP_NONE 4'h0
`define MCI_OP_MAC_LONG 4'h1
`define MCI_OP_MAC_WORD 4'h2
`define MCI_OP_DMUL_LONG 4'h3
`define MCI_OP_MUL_WORD 4'h4
`define MCI_OP_ST_GPR 4'h5
`define MCI_OP_ST_MEM 4'h6
`define MCI_OP_LD_GPR 4'h7
`define MCI_OP_LD_MEM 4'h8

// Multiplier busy cycles after the last memory access stage
`define MCI_BUSY_W 3
`define MCI_BUSY_MAC_LONG 3'h4
`define MCI_BUSY_MAC_WORD 3'h2
`define MCI_BUSY_DMUL_LONG 3'h4
`define MCI_BUSY_MUL_WORD 3'h2

// Memory access phase, one-hot
`define MCI_PH_W 3
`define MCI_PH_IDLE 3'h1
`define MCI_PH_FIRST 3'h2
`define MCI_PH_LAST 3'h4

`endif
